// ---- design/dp_pkg.sv ----
/*
  Holds the shared constants of the byte datapath slice: widths, config
  word fields, routing input positions, condition indices, reset values.
  Assumes nothing of its surroundings.
*/
package dp_pkg;

  // ==========================================================
  // widths and depths
  localparam int DW         = 8;
  localparam int CFG_W      = 16;
  localparam int CFG_DEPTH  = 8;
  localparam int CFG_AW     = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int RT_W       = 6;
  localparam int SEL_W      = 4;
  localparam int SC_W       = 8;
  localparam int COND_W     = 16;

  // ==========================================================
  // config word field positions
  localparam int CF_OP   = 0;   // 3 bits alu operation
  localparam int CF_SRCA = 3;   // 2 bits operand a
  localparam int CF_SRCB = 5;   // 2 bits operand b / polynomial
  localparam int CF_SH   = 7;   // 2 bits shift function
  localparam int CF_ORM  = 9;   // or mask enable
  localparam int CF_DST  = 10;  // 2 bits accumulator destination
  localparam int CF_CIR  = 12;  // carry in from registered carry
  localparam int CF_SIR  = 13;  // shift in from registered shift out
  localparam int CF_CFB  = 14;  // crc / prs feedback enable
  localparam int CF_CAP  = 15;  // output fifo captures alu result

  // ==========================================================
  // routing input positions
  localparam int RI_ADDR = 0;   // 3 bits config address
  localparam int RI_SI   = 3;   // serial data in
  localparam int RI_F0   = 4;   // fifo_zero strobe
  localparam int RI_F1   = 5;   // fifo_one strobe

  // ==========================================================
  // condition vector indices
  localparam int C_CE0 = 0;
  localparam int C_CL0 = 1;
  localparam int C_CE1 = 2;
  localparam int C_CL1 = 3;
  localparam int C_Z0  = 4;
  localparam int C_Z1  = 5;
  localparam int C_FF0 = 6;
  localparam int C_FF1 = 7;
  localparam int C_OV  = 8;
  localparam int C_CO  = 9;
  localparam int C_SO  = 10;
  localparam int C_F0E = 11;
  localparam int C_F0F = 12;
  localparam int C_F1E = 13;
  localparam int C_F1F = 14;
  localparam int C_CRG = 15;

  // ==========================================================
  // reset values
  localparam logic [CFG_W-1:0] CFG_RST  = 16'h0000;
  localparam logic [DW-1:0]    WORK_RST = 8'h00;
  localparam logic [SC_W-1:0]  CTRL_RST = 8'h00;

  typedef enum logic [2:0] {
    OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_PASS
  } alu_op_t;

  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} shift_t;
  typedef enum logic [1:0] {DST_NONE, DST_A0, DST_A1, DST_BOTH} dest_t;

endpackage

// ---- design/dp_cfg_ram.sv ----
/*
  Eight word configuration memory with registered read data.
  Assumes writes come from the bus side on the same clock.
*/
`timescale 1ns/1ps
module dp_cfg_ram
  import dp_pkg::*;
#(
  parameter int W     = CFG_W,
  parameter int DEPTH = CFG_DEPTH,
  parameter int AW    = CFG_AW
)(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];

  // ==========================================================
  // storage write
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // registered read, cleared by reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data <= CFG_RST;
    else
      rd_data <= mem[rd_addr];
  end
endmodule // dp_cfg_ram

// ---- design/dp_fifo.sv ----
/*
  Small byte FIFO with valid/ready on both sides and empty/full flags.
  Assumes both sides run on clk; pushes on full and pops on empty are
  refused by the ready/valid terms.
*/
`timescale 1ns/1ps
module dp_fifo
  import dp_pkg::*;
#(
  parameter int W     = DW,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data,
  output logic              empty,
  output logic              full
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0]   cnt_r;
  logic          push;
  logic          pop;

  // stall on full and empty, no overflow or underflow
  assign full      = (cnt_r == (PW+1)'(DEPTH));
  assign empty     = (cnt_r == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[rp_r];

  // ==========================================================
  // storage and pointers
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= PW'(wp_r + 1'b1);
      if (pop)
        rp_r <= PW'(rp_r + 1'b1);
      cnt_r <= (PW+1)'(cnt_r + push - pop);
    end
  end

  fifo_full_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    full && !out_ready |=> full && !in_ready)
    else $error("fifo left full without a pop");
endmodule // dp_fifo

// ---- design/dp_slice.sv ----
/*
  Byte wide configurable datapath slice with its status/control unit.
  Assumes routing inputs come from logic on clk (no synchronisers) and
  that the routing side supplies config address and serial data.
*/
`timescale 1ns/1ps
module dp_slice
  import dp_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
)(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [RT_W-1:0]     route_in,
  output logic      [RT_W-1:0]     route_out,
  input  wire logic [RT_W*SEL_W-1:0] out_sel,
  input  wire logic                cfg_wr_en,
  input  wire logic [CFG_AW-1:0]   cfg_wr_addr,
  input  wire logic [CFG_W-1:0]    cfg_wr_data,
  input  wire logic                bus_reg_wr,
  input  wire logic [1:0]          bus_reg_sel,
  input  wire logic [DW-1:0]       bus_reg_wdata,
  output logic      [DW-1:0]       accumulator_zero,
  output logic      [DW-1:0]       accumulator_one,
  output logic      [DW-1:0]       data_reg_zero,
  output logic      [DW-1:0]       data_reg_one,
  input  wire logic [2:0]          msb_sel,
  input  wire logic [DW-1:0]       alu_mask,
  input  wire logic [DW-1:0]       or_mask,
  input  wire logic [1:0]          cmp_mode,
  input  wire logic [DW-1:0]       cmp0_mask,
  input  wire logic [DW-1:0]       cmp1_mask,
  input  wire logic                chain_en,
  input  wire logic                chain_ci,
  input  wire logic                chain_si,
  input  wire logic                chain_ce_in,
  output logic                     chain_co,
  output logic                     chain_so,
  output logic                     chain_ce_out,
  input  wire logic                fifo_zero_dir,
  input  wire logic                fifo_one_dir,
  input  wire logic                bus_f0_wr_valid,
  output logic                     bus_f0_wr_ready,
  input  wire logic [DW-1:0]       bus_f0_wr_data,
  output logic                     bus_f0_rd_valid,
  input  wire logic                bus_f0_rd_ready,
  output logic      [DW-1:0]       bus_f0_rd_data,
  input  wire logic                bus_f1_wr_valid,
  output logic                     bus_f1_wr_ready,
  input  wire logic [DW-1:0]       bus_f1_wr_data,
  output logic                     bus_f1_rd_valid,
  input  wire logic                bus_f1_rd_ready,
  output logic      [DW-1:0]       bus_f1_rd_data,
  input  wire logic                dp_run_sel,
  input  wire logic [2:0]          dp_run_bit,
  input  wire logic                sc_run,
  input  wire logic                ctrl_wr,
  input  wire logic [SC_W-1:0]     ctrl_wdata,
  input  wire logic [SC_W-1:0]     ctrl_route_en,
  output logic      [SC_W-1:0]     ctrl_out,
  input  wire logic [SC_W-1:0]     status_in,
  input  wire logic [SC_W-1:0]     status_route_en,
  input  wire logic                status_rd,
  output logic      [SC_W-1:0]     status_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [DW-1:0]     work_r [4];  // a0, a1, d0, d1
  logic [CFG_W-1:0]  cfg_r;
  logic [SC_W-1:0]   ctrl_r;
  logic [SC_W-1:0]   status_r;
  logic [RT_W-1:0]   route_out_r;
  logic              carry_r;
  logic              shift_r;
  logic              dp_run;
  logic [DW-1:0]     opa, opb, bx, alu, sh, res;
  logic [DW:0]       sum9;
  logic              cin, si, co, so, ov, fb;
  logic              ce0, cl0, ce1, cl1;
  logic [COND_W-1:0] cond_vec;
  alu_op_t           op;
  shift_t            sfn;
  dest_t             dst;
  logic              f0_iv, f0_ir, f0_ov, f0_or, f0_e, f0_f;
  logic              f1_iv, f1_ir, f1_ov, f1_or, f1_e, f1_f;
  logic [DW-1:0]     f0_id, f1_id, f0_od, f1_od;

  // ==========================================================
  // helper functions
  function automatic logic [DW-1:0] pick(input logic [1:0] s);
    pick = work_r[s];
  endfunction

  // carry into bit m, which is the carry out of the chosen msb when m is the bit above it
  function automatic logic carry_at(input logic [DW:0] a9, b9, s9,
                                    input int m);
    carry_at = s9[m] ^ a9[m] ^ b9[m];
  endfunction

  function automatic logic [1:0] cmp(input logic [DW-1:0] a, b, k);
    cmp = {((a & k) < (b & k)), ((a & k) == (b & k))};
  endfunction

  assign op  = alu_op_t'(cfg_r[CF_OP +: 3]);
  assign sfn = shift_t'(cfg_r[CF_SH +: 2]);
  assign dst = dest_t'(cfg_r[CF_DST +: 2]);

  // ==========================================================
  // config memory, addressed from routing
  // per-cycle config select
  dp_cfg_ram u_cfg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (cfg_wr_en),
    .wr_addr (cfg_wr_addr),
    .wr_data (cfg_wr_data),
    .rd_addr (route_in[RI_ADDR +: CFG_AW]),
    .rd_data (cfg_r)
  );

  // ==========================================================
  // alu, shifter and masks
  always_comb
  begin
    opa = pick(cfg_r[CF_SRCA +: 2]);
    opb = pick(cfg_r[CF_SRCB +: 2]);
    case (op)
      OP_INC:  begin bx = '0;   cin = 1'b1; end
      OP_DEC:  begin bx = '1;   cin = 1'b0; end
      OP_ADD:  begin bx = opb;  cin = 1'b0; end
      OP_SUB:  begin bx = ~opb; cin = 1'b1; end
      default: begin bx = opb;  cin = 1'b0; end
    endcase
    if (cfg_r[CF_CIR])
      cin = carry_r;
    if (chain_en)
      cin = chain_ci;
    sum9 = (DW+1)'({1'b0, opa} + {1'b0, bx} + (DW+1)'(cin));
    case (op)
      OP_AND:  alu = opa & opb;
      OP_OR:   alu = opa | opb;
      OP_XOR:  alu = opa ^ opb;
      OP_PASS: alu = opa;
      default: alu = sum9[DW-1:0];
    endcase
    // carry and overflow at the chosen msb
    co = carry_at({1'b0, opa}, {1'b0, bx}, sum9, int'(msb_sel) + 1);
    ov = (op inside {OP_INC, OP_DEC, OP_ADD, OP_SUB}) &&
         (co ^ carry_at({1'b0, opa}, {1'b0, bx}, sum9, int'(msb_sel)));
    si = chain_en ? chain_si : (cfg_r[CF_SIR] ? shift_r : route_in[RI_SI]);
    fb = alu[msb_sel] ^ si;
    case (sfn)
      SH_LEFT:
      begin
        // crc/prs step with operand b as polynomial
        sh = cfg_r[CF_CFB] ? ({alu[DW-2:0], 1'b0} ^ (opb & {DW{fb}}))
                           : {alu[DW-2:0], si};
        so = alu[msb_sel];
      end
      SH_RIGHT:
      begin
        // serial in lands at the msb
        sh          = alu >> 1;
        sh[msb_sel] = si;
        so          = alu[0];
      end
      SH_SWAP:
      begin
        sh = {alu[3:0], alu[7:4]};
        so = 1'b0;
      end
      default:
      begin
        sh = alu;
        so = 1'b0;
      end
    endcase
    res = (cfg_r[CF_ORM] ? (sh | or_mask) : sh) & alu_mask;
  end

  // ==========================================================
  // compares and condition vector
  always_comb
  begin
    case (cmp_mode)
      2'd0:    begin {cl0, ce0} = cmp(work_r[0], work_r[2], cmp0_mask);
                     {cl1, ce1} = cmp(work_r[1], work_r[3], cmp1_mask); end
      2'd1:    begin {cl0, ce0} = cmp(work_r[0], work_r[1], cmp0_mask);
                     {cl1, ce1} = cmp(work_r[1], work_r[3], cmp1_mask); end
      2'd2:    begin {cl0, ce0} = cmp(work_r[0], work_r[2], cmp0_mask);
                     {cl1, ce1} = cmp(work_r[0], work_r[3], cmp1_mask); end
      default: begin {cl0, ce0} = cmp(work_r[1], work_r[2], cmp0_mask);
                     {cl1, ce1} = cmp(work_r[1], work_r[3], cmp1_mask); end
    endcase
    cond_vec        = '0;
    cond_vec[C_CE0] = ce0;
    cond_vec[C_CL0] = cl0;
    cond_vec[C_CE1] = ce1;
    cond_vec[C_CL1] = cl1;
    cond_vec[C_Z0]  = (work_r[0] == '0);
    cond_vec[C_Z1]  = (work_r[1] == '0);
    cond_vec[C_FF0] = (work_r[0] == '1);
    cond_vec[C_FF1] = (work_r[1] == '1);
    cond_vec[C_OV]  = ov;
    cond_vec[C_CO]  = co;
    cond_vec[C_SO]  = so;
    cond_vec[C_F0E] = f0_e;
    cond_vec[C_F0F] = f0_f;
    cond_vec[C_F1E] = f1_e;
    cond_vec[C_F1F] = f1_f;
    cond_vec[C_CRG] = ce0 && (chain_en ? chain_ce_in : 1'b1);
  end

  assign chain_co     = co;
  assign chain_so     = so;
  assign chain_ce_out = cond_vec[C_CRG];

  assign dp_run = dp_run_sel ? ctrl_r[dp_run_bit] : 1'b1;

  // ==========================================================
  // fifo hookup; dir 1 = output, 0 = input
  // direction steers writer and reader
  assign f0_iv = fifo_zero_dir ? (dp_run && route_in[RI_F0])
                               : bus_f0_wr_valid;
  assign f0_id = fifo_zero_dir ? (cfg_r[CF_CAP] ? res : work_r[0])
                               : bus_f0_wr_data;
  assign f0_or = fifo_zero_dir ? bus_f0_rd_ready
                               : (dp_run && route_in[RI_F0]);
  assign f1_iv = fifo_one_dir ? (dp_run && route_in[RI_F1])
                              : bus_f1_wr_valid;
  assign f1_id = fifo_one_dir ? (cfg_r[CF_CAP] ? res : work_r[1])
                              : bus_f1_wr_data;
  assign f1_or = fifo_one_dir ? bus_f1_rd_ready
                              : (dp_run && route_in[RI_F1]);
  assign bus_f0_wr_ready = !fifo_zero_dir && f0_ir;
  assign bus_f0_rd_valid = fifo_zero_dir && f0_ov;
  assign bus_f0_rd_data  = f0_od;
  assign bus_f1_wr_ready = !fifo_one_dir && f1_ir;
  assign bus_f1_rd_valid = fifo_one_dir && f1_ov;
  assign bus_f1_rd_data  = f1_od;

  dp_fifo #(.W(DW), .DEPTH(FIFO_D)) u_f0 (
    .clk (clk), .sys_rst (sys_rst),
    .in_valid (f0_iv), .in_ready (f0_ir), .in_data (f0_id),
    .out_valid (f0_ov), .out_ready (f0_or), .out_data (f0_od),
    .empty (f0_e), .full (f0_f)
  );

  dp_fifo #(.W(DW), .DEPTH(FIFO_D)) u_f1 (
    .clk (clk), .sys_rst (sys_rst),
    .in_valid (f1_iv), .in_ready (f1_ir), .in_data (f1_id),
    .out_valid (f1_ov), .out_ready (f1_or), .out_data (f1_od),
    .empty (f1_e), .full (f1_f)
  );

  // ==========================================================
  // working registers: bus write, fifo load, then alu
  // bus access to working registers
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (sys_rst)
        work_r[i] <= WORK_RST;
      else if (bus_reg_wr && (bus_reg_sel == 2'(i)))
        work_r[i] <= bus_reg_wdata;
      else if (i == 2 && !fifo_zero_dir && f0_or && f0_ov)
        work_r[i] <= f0_od;
      else if (i == 3 && !fifo_one_dir && f1_or && f1_ov)
        work_r[i] <= f1_od;
      else if (i < 2 && dp_run &&
               (dst == DST_BOTH || dst == dest_t'(2'(i + 1))))
        work_r[i] <= res;
    end
  end

  assign accumulator_zero = work_r[0];
  assign accumulator_one  = work_r[1];
  assign data_reg_zero    = work_r[2];
  assign data_reg_one     = work_r[3];

  // registered carry and shift for time sharing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      carry_r <= 1'b0;
      shift_r <= 1'b0;
    end
    else if (dp_run)
    begin
      carry_r <= co;
      shift_r <= so;
    end
  end

  // ==========================================================
  // routed outputs
  // conditions onto routing
  always_ff @(posedge clk)
  begin
    for (int k = 0; k < RT_W; k++)
    begin
      if (sys_rst)
        route_out_r[k] <= 1'b0;
      else
        route_out_r[k] <= cond_vec[out_sel[k*SEL_W +: SEL_W]];
    end
  end
  assign route_out = route_out_r;

  // ==========================================================
  // status and control unit
  // bus written control register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_r <= CTRL_RST;
    else if (sc_run && ctrl_wr)
      ctrl_r <= ctrl_wdata;
  end
  assign ctrl_out = ctrl_r & ctrl_route_en;

  // status sampled from routing on a read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      status_r <= CTRL_RST;
    else if (sc_run && status_rd)
      status_r <= status_in & status_route_en;
  end
  assign status_rdata = status_r;

  // ==========================================================
  // checks
  sequence f0_bus_push;
    !fifo_zero_dir && bus_f0_wr_valid && bus_f0_wr_ready;
  endsequence
  sequence f0_now_filled;
    !f0_e ##0 !fifo_zero_dir;
  endsequence

  fifo_in_push_a: assert property (f0_bus_push |=> f0_now_filled)
    else $error("bus push did not fill fifo_zero");
  fifo_wr_stall_a: assert property (f0_f |-> !bus_f0_wr_ready)
    else $error("bus write offered on full fifo");
  ctrl_drive_a: assert property (sc_run && ctrl_wr ##1 $stable(ctrl_route_en)
    |-> ctrl_out == ($past(ctrl_wdata) & ctrl_route_en))
    else $error("control write not seen on routing");
  status_hold_a: assert property (!(sc_run && status_rd)
    |=> $stable(status_rdata))
    else $error("status changed without read");
  status_sample_a: assert property (sc_run && status_rd
    |=> status_rdata == $past(status_in & status_route_en))
    else $error("status sample mismatch");
  carry_reg_a: assert property (dp_run |=> carry_r == $past(co))
    else $error("carry not registered");
  run_gate_a: assert property (!dp_run && !bus_reg_wr
    |=> $stable(accumulator_zero) && $stable(accumulator_one))
    else $error("accumulator moved while slice stopped");
  route_sel_a: assert property (##1 $stable(out_sel)
    |-> route_out[0] == $past(cond_vec[out_sel[SEL_W-1:0]]))
    else $error("routed output not the selected condition");
  zero_det_a: assert property (accumulator_zero == '0 |-> cond_vec[C_Z0]
    && !cond_vec[C_FF0])
    else $error("zero detect wrong");
endmodule // dp_slice

// ---- tb/route_model.sv ----
/*
  routing-side partner: drives config address and fifo_zero strobe.
  assumes one clk shared with the slice; serial in stays low.
*/
`timescale 1ns/1ps
module route_model
  import dp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [2:0]      addr,
  input  wire logic            pop0,
  output logic      [RT_W-1:0] route_in
);
  // ==========================================================
  // registered drive; idle selects entry 0
  // config select, serial in
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      route_in <= '0;
    else
      route_in <= {1'b0, pop0, 1'b0, addr};
  end
endmodule // route_model

// ---- tb/testbench.sv ----
/*
  bench for dp_slice: alu table, conditions, fifo, control, status.
  assumes dp_pkg and route_model on one 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench
  import dp_pkg::*;
;
  logic        clk, sys_rst, cfg_we, reg_wr, ctrl_wr, st_rd, sc_run;
  logic        f0_wv, f0_wr, f0_rv, pop0, run_sel;
  logic [2:0]  addr, cfg_wa;
  logic [1:0]  reg_sel;
  logic [15:0] cfg_wd;
  logic [7:0]  reg_wd, f0_wd, a0, d0, ctrl_wd, ctrl_out, st_in, st_rd_q;
  logic [5:0]  route_in, route_out;
  logic        chain_en, f0_dir, f1_dir, f0_rr, f1_wv, f1_rr;
  logic [1:0]  cmp_mode;
  logic [2:0]  msb_sel, run_bit;
  logic [7:0]  alu_mask, or_mask, cmp0_mask, cmp1_mask, ctrl_en, st_en;
  logic [7:0]  f0_rd;
  logic [23:0] out_sel;
  logic [15:0] cfg_t [12];
  logic [7:0]  exp_t [12];
  int          num_errors, tests_run, k, n;

  // ==========================================================
  // slice and routing partner
  dp_slice #(.FIFO_D(4)) dp_slice_i (
    .clk(clk), .sys_rst(sys_rst), .route_in(route_in),
    .route_out(route_out), .out_sel(out_sel), .cfg_wr_en(cfg_we),
    .cfg_wr_addr(cfg_wa), .cfg_wr_data(cfg_wd), .bus_reg_wr(reg_wr),
    .bus_reg_sel(reg_sel), .bus_reg_wdata(reg_wd),
    .accumulator_zero(a0), .accumulator_one(), .data_reg_zero(d0),
    .data_reg_one(), .msb_sel(msb_sel), .alu_mask(alu_mask),
    .or_mask(or_mask), .cmp_mode(cmp_mode), .cmp0_mask(cmp0_mask),
    .cmp1_mask(cmp1_mask), .chain_en(chain_en), .chain_ci(1'b0),
    .chain_si(1'b0), .chain_ce_in(1'b0), .chain_co(), .chain_so(),
    .chain_ce_out(), .fifo_zero_dir(f0_dir), .fifo_one_dir(f1_dir),
    .bus_f0_wr_valid(f0_wv), .bus_f0_wr_ready(f0_wr),
    .bus_f0_wr_data(f0_wd), .bus_f0_rd_valid(f0_rv),
    .bus_f0_rd_ready(f0_rr), .bus_f0_rd_data(f0_rd),
    .bus_f1_wr_valid(f1_wv), .bus_f1_wr_ready(), .bus_f1_wr_data(8'h00),
    .bus_f1_rd_valid(), .bus_f1_rd_ready(f1_rr), .bus_f1_rd_data(),
    .dp_run_sel(run_sel), .dp_run_bit(run_bit), .sc_run(sc_run),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wd), .ctrl_route_en(ctrl_en),
    .ctrl_out(ctrl_out), .status_in(st_in), .status_route_en(st_en),
    .status_rd(st_rd), .status_rdata(st_rd_q)
  );

  route_model route_model_i (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .pop0(pop0),
    .route_in(route_in)
  );

  // ==========================================================
  // clock and helper tasks
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, s);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // all four working registers get the same byte
  task automatic fill(input logic [7:0] v);
    reg_wd = v;
    reg_wr = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      reg_sel = s[1:0];
      tick(1);
    end
    reg_wr = 1'b0;
  endtask

  // entry 1 gets word w, then one cycle selects it
  task automatic step(input logic [15:0] w);
    cfg_wa = 3'd1;
    cfg_wd = w;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    addr = 3'd1;
    tick(1);
    addr = 3'd0;
    tick(4);
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {sys_rst, cfg_we, reg_wr, ctrl_wr, st_rd, f0_wv, pop0} = 7'h40;
    {cfg_wa, addr, reg_sel, cfg_wd, reg_wd, f0_wd, ctrl_wd, st_in} = '0;
    // slice held still until every config entry holds a known word
    {sc_run, run_sel} = 2'h3;
    {chain_en, f0_dir, f1_dir, f0_rr, f1_wv, f1_rr} = 6'h0c;
    {out_sel, msb_sel, run_bit, cmp_mode} = {24'h00cb04, 3'h7, 3'h1, 2'h0};
    {alu_mask, or_mask, cmp0_mask, cmp1_mask} = 32'hff81_ffff;
    {ctrl_en, st_en} = 16'h0fff;
    cfg_t = '{16'h0400, 16'h0401, 16'h0402, 16'h0403, 16'h0404, 16'h0405,
              16'h0406, 16'h0407, 16'h0487, 16'h0507, 16'h0587, 16'h0607};
    exp_t = '{8'h5b, 8'h59, 8'hb4, 8'h00, 8'h5a, 8'h5a, 8'h00, 8'h5a,
              8'hb4, 8'h2d, 8'ha5, 8'hdb};
    tick(8);
    sys_rst = 1'b0;
    // idle word in every entry, then a second reset
    cfg_we = 1'b1;
    for (k = 0; k < 8; k++)
    begin
      cfg_wa = k[2:0];
      tick(1);
    end
    cfg_we = 1'b0;
    sys_rst = 1'b1;
    tick(2);
    chk("acc0 rst", 8'h00, a0);
    chk("route rst", 8'h00, {2'b00, route_out});
    chk("ctrl rst", 8'h00, ctrl_out);
    sys_rst = 1'b0;
    run_sel = 1'b0;
    // operation table
    for (k = 0; k < 12; k++)
    begin
      fill(8'h5a);
      step(cfg_t[k]);
      chk("acc0", exp_t[k], a0);
      chk("zero", {7'b0, exp_t[k] == 8'h00}, {7'b0, route_out[0]});
    end
    // four bit counter wraps at the chosen msb under the output mask
    {msb_sel, alu_mask} = {3'h3, 8'h0f};
    fill(8'h0f);
    step(16'h0400);
    chk("msb wrap", 8'h00, a0);
    {msb_sel, alu_mask} = {3'h7, 8'hff};
    // compare a0 against a1, plain and masked
    fill(8'h5a);
    tick(1);
    {reg_sel, reg_wd, reg_wr} = {2'h1, 8'h5b, 1'b1};
    tick(1);
    {reg_wr, cmp_mode} = {1'b0, 2'h1};
    tick(2);
    chk("ce0 a0-a1", 8'h00, {7'b0, route_out[1]});
    cmp0_mask = 8'hfe;
    tick(2);
    chk("ce0 masked", 8'h01, {7'b0, route_out[1]});
    {cmp_mode, cmp0_mask} = {2'h0, 8'hff};
    // fifo_zero input: push until refused
    n = 0;
    f0_wv = 1'b1;
    for (k = 0; k < 6; k++)
    begin
      f0_wd = 8'h10 + n[7:0];
      if (f0_wr === 1'b1)
        n++;
      tick(1);
    end
    f0_wv = 1'b0;
    chk("f0 count", 8'd4, n[7:0]);
    chk("f0 full", 8'h01, {7'b0, route_out[3]});
    chk("f0 rd", 8'h00, {7'b0, f0_rv});
    // drain through route strobe, one pop past empty
    for (k = 0; k < 5; k++)
    begin
      pop0 = 1'b1;
      tick(1);
      pop0 = 1'b0;
      tick(3);
      chk("d0 pop", (k < 4) ? 8'h10 + k[7:0] : 8'h13, d0);
    end
    chk("f0 empty", 8'h01, {7'b0, route_out[2]});
    // control write, then write while stopped
    ctrl_wd = 8'ha5;
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
    sc_run = 1'b0;
    tick(1);
    chk("ctrl", 8'h05, ctrl_out);
    ctrl_wd = 8'hff;
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
    sc_run = 1'b1;
    tick(1);
    chk("ctrl held", 8'h05, ctrl_out);
    // control bit 1 low gates the alu
    run_sel = 1'b1;
    fill(8'h5a);
    step(16'h0400);
    chk("gated", 8'h5a, a0);
    run_sel = 1'b0;
    step(16'h0400);
    chk("ungated", 8'h5b, a0);
    // status sample holds between reads
    st_in = 8'h3c;
    st_rd = 1'b1;
    tick(1);
    st_rd = 1'b0;
    st_in = 8'hc3;
    tick(3);
    chk("status", 8'h3c, st_rd_q);
    // fifo_zero turned round: slice writes a0, bus reads it
    f0_rr  = 1'b0;
    f0_dir = 1'b1;
    pop0   = 1'b1;
    tick(1);
    pop0 = 1'b0;
    tick(3);
    chk("f0 out valid", 8'h01, {7'b0, f0_rv});
    chk("f0 out data", 8'h5b, f0_rd);
    f0_rr = 1'b1;
    tick(1);
    chk("f0 out drained", 8'h00, {7'b0, f0_rv});
    print_verdict();
  end
endmodule // testbench
